// ### core/tbdb_blinker.sv
`timescale 1ns/1ps
module tbdb_blinker
    import tbdb_pkg::*;
#(
    parameter int unsigned P_FAST_HALF = FAST_HALF_CYC,
    parameter int unsigned P_SLOW_HALF = SLOW_HALF_CYC,
    parameter int unsigned P_PAUSE = PAUSE_CYC,
    parameter int unsigned P_GAP = GAP_CYC
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Terminal bus monitor pins
    input wire logic term_state_err,
    input wire logic pd_len_err,
    input wire logic no_valid_inputs,
    input wire logic in_update_busy,
    input wire logic out_update_busy,
    input wire logic watchdog_err,
    input wire logic bus_async,
    input wire logic fieldbus_running,
    input wire logic cmd_err,
    input wire logic fault_strobe,
    input wire logic [3:0] fault_code,
    input wire logic [3:0] fault_slot,
    input wire logic [15:0] passive_map,
    // Indicators and interrupt
    output logic red_led,
    output logic green_led,
    output logic irq
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [IN_W-1:0] s1;
        logic [IN_W-1:0] s2;
        logic stb_prev;
        logic cmd_prev;
        logic pdl_prev;
        logic [15:0] status;
        logic fault;
        logic [3:0] code;
        logic [4:0] arg;
        tbdb_blink_e state;
        logic [CNT_W-1:0] cnt;
        logic [TIMER_W-1:0] timer;
        logic red;
        logic green;
        logic [3:0] irq_stat;
        logic [3:0] irq_mask;
        logic blink_en;
        logic irq;
        logic a_valid;
        logic a_write;
        logic [7:0] a_addr;
        logic [31:0] hrdata;
        logic hready;
        logic [1:0] warm;
    } tbdb_state_s;
    localparam logic [TIMER_W-1:0] T_FAST = TIMER_W'(P_FAST_HALF - 1);
    localparam logic [TIMER_W-1:0] T_SLOW = TIMER_W'(P_SLOW_HALF - 1);
    localparam logic [TIMER_W-1:0] T_PAUSE = TIMER_W'(P_PAUSE - 1);
    localparam logic [TIMER_W-1:0] T_GAP = TIMER_W'(P_GAP - 1);
    tbdb_state_s q;
    tbdb_state_s d;
    logic [IN_W-1:0] pins;
    // Counts the active terminals that stand in front of the faulty slot.
    function automatic logic [4:0] active_before(input logic [15:0] map,
                                                 input logic [3:0] slot);
        logic [4:0] c;
        c = 5'h00;
        for (int i = 0; i < 16; i++) begin
            if (i < int'(slot) && !map[i]) begin
                c = c + 5'h01;
            end
        end
        return c;
    endfunction : active_before
    assign pins = {passive_map, fault_slot, fault_code, fault_strobe, cmd_err,
                   fieldbus_running, bus_async, watchdog_err, out_update_busy,
                   in_update_busy, no_valid_inputs, pd_len_err, term_state_err};
    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic s_term;
        logic s_pdl;
        logic s_noin;
        logic s_inu;
        logic s_outu;
        logic s_wdog;
        logic s_async;
        logic new_fault;
        logic expired;
        logic addr_ok;
        logic [3:0] ev;
        logic [3:0] clr;
        logic [15:0] st;
        d = q;
        s_term = q.s2[0];
        s_pdl = q.s2[1];
        s_noin = q.s2[2];
        s_inu = q.s2[3];
        s_outu = q.s2[4];
        s_wdog = q.s2[5];
        s_async = q.s2[6];
        new_fault = 1'b0;
        ev = 4'h0;
        clr = 4'h0;
        expired = (q.timer == '0);
        addr_ok = 1'b0;
        st = 16'h0000;
        // Two flops before any logic looks at a pin.
        d.s1 = pins;
        d.s2 = q.s1;
        d.stb_prev = q.s2[IX_STB];
        d.cmd_prev = q.s2[IX_CMD];
        d.pdl_prev = s_pdl;
        if (q.warm != 2'h3) begin
            d.warm = q.warm + 2'h1;
        end
        // Only the first fault is kept, so the report names the root cause.
        if (!q.fault) begin
            if (q.s2[IX_CMD] && !q.cmd_prev) begin
                new_fault = 1'b1;
                d.code = CODE_CMD_ERR;
                d.arg = 5'h00;
            end else if (s_pdl && !q.pdl_prev) begin
                new_fault = 1'b1;
                d.code = CODE_PD_LEN;
                d.arg = 5'h00;
            end else if (q.s2[IX_STB] && !q.stb_prev
                         && q.s2[IX_CODE +: 4] != 4'h0) begin
                new_fault = 1'b1;
                d.code = q.s2[IX_CODE +: 4];
                d.arg = active_before(q.s2[IX_PASSIVE +: 16], q.s2[IX_SLOT +: 4]);
            end
        end
        d.fault = q.fault | new_fault;
        st[ST_FAULT] = d.fault;
        st[ST_TERM_ERR] = s_term;
        st[ST_PD_LEN] = s_pdl;
        st[ST_NO_INPUT] = s_noin;
        st[ST_IN_UPD] = s_inu;
        st[ST_OUT_UPD] = s_outu;
        st[ST_WDOG] = s_wdog;
        st[ST_ASYNC] = s_async;
        d.status = st;

        d.green = q.s2[IX_FB_RUN] && ((st & ST_ERR_MASK) == 16'h0000);

        // ************************************************************
        // Blink sequencer
        // ************************************************************
        if (!expired) begin
            d.timer = q.timer - 1'b1;
        end
        case (q.state)
            BL_IDLE: begin
                d.red = 1'b0;
                if (q.fault && q.blink_en) begin
                    d.state = BL_PRE;
                    d.red = 1'b1;
                    d.cnt = '0;
                    d.timer = T_FAST;
                end
            end
            BL_PRE: begin
                if (expired) begin
                    if (q.red) begin
                        d.red = 1'b0;
                        d.cnt = q.cnt + 1'b1;
                        d.timer = T_FAST;
                    end else if (q.cnt == PREAMBLE_PULSES) begin
                        d.state = BL_CODE;
                        d.red = 1'b1;
                        d.cnt = '0;
                        d.timer = T_SLOW;
                    end else begin
                        d.red = 1'b1;
                        d.timer = T_FAST;
                    end
                end
            end
            BL_CODE: begin
                if (expired) begin
                    if (q.red) begin
                        d.red = 1'b0;
                        d.cnt = q.cnt + 1'b1;
                        d.timer = T_SLOW;
                    end else if (q.cnt == CNT_W'(q.code)) begin
                        d.state = BL_PAUSE;
                        d.timer = T_PAUSE;
                    end else begin
                        d.red = 1'b1;
                        d.timer = T_SLOW;
                    end
                end
            end
            BL_PAUSE: begin
                d.red = 1'b0;
                if (expired) begin
                    d.cnt = '0;
                    if (q.arg == 5'h00) begin
                        d.state = BL_GAP;
                        d.timer = T_GAP;
                    end else begin
                        d.state = BL_ARG;
                        d.red = 1'b1;
                        d.timer = T_SLOW;
                    end
                end
            end
            BL_ARG: begin
                if (expired) begin
                    if (q.red) begin
                        d.red = 1'b0;
                        d.cnt = q.cnt + 1'b1;
                        d.timer = T_SLOW;
                    end else if (q.cnt == q.arg) begin
                        d.state = BL_GAP;
                        d.timer = T_GAP;
                    end else begin
                        d.red = 1'b1;
                        d.timer = T_SLOW;
                    end
                end
            end
            BL_GAP: begin
                d.red = 1'b0;
                if (expired) begin
                    d.state = BL_IDLE;
                end
            end
            default: begin
                d.state = BL_IDLE;
                d.red = 1'b0;
            end
        endcase
        if (!q.fault) begin
            d.red = 1'b0;
            d.state = BL_IDLE;
        end

        // ************************************************************
        // Bus slave and interrupts
        // ************************************************************
        d.hready = 1'b1;
        d.a_valid = hsel && hready && htrans[1];
        d.a_write = hwrite;
        d.a_addr = haddr[7:0];
        if (hsel && hready && htrans[1] && !hwrite) begin
            addr_ok = (haddr[31:8] == 24'h000000);
            d.hrdata = 32'h00000000;
            if (addr_ok) begin
                case (haddr[7:0])
                    STATUS_OFS: d.hrdata = {16'h0000, q.status};
                    FAULT_OFS: d.hrdata = {19'h00000, q.arg, q.code, 3'h0, q.fault};
                    IRQ_STAT_OFS: d.hrdata = {28'h0000000, q.irq_stat};
                    IRQ_MASK_OFS: d.hrdata = {28'h0000000, q.irq_mask};
                    CTRL_OFS: d.hrdata = {31'h00000000, q.blink_en};
                    default: d.hrdata = 32'h00000000;
                endcase
            end
        end
        if (q.a_valid && q.a_write) begin
            case (q.a_addr)
                IRQ_STAT_OFS: clr = hwdata[3:0];
                IRQ_MASK_OFS: d.irq_mask = hwdata[3:0];
                CTRL_OFS: d.blink_en = hwdata[0];
                default: begin
                end
            endcase
        end
        ev[EV_FAULT] = new_fault;
        ev[EV_WDOG] = s_wdog && !q.status[ST_WDOG];
        ev[EV_TERM] = s_term && !q.status[ST_TERM_ERR];
        ev[EV_ASYNC] = s_async && !q.status[ST_ASYNC];
        // A set in the clearing cycle wins, so no event is lost.
        d.irq_stat = (q.irq_stat & ~clr) | ev;
        d.irq = |(d.irq_stat & d.irq_mask);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
            q.state <= BL_IDLE;
            q.blink_en <= CTRL_BLINK_EN_RST;
            q.irq_mask <= IRQ_MASK_RST;
            q.hready <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign hrdata = q.hrdata;
    assign hreadyout = q.hready;
    assign hresp = 1'b0;
    assign red_led = q.red;
    assign green_led = q.green;
    assign irq = q.irq;

    // ****************************************************************
    // Checks
    // ****************************************************************
    red_dark_a: assert property (
        @(posedge hclk) disable iff (!hresetn) !q.fault |-> ##1 !red_led)
        else $error("red indicator lit without a fault");
    flash_start_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (q.fault && q.blink_en && q.state == BL_IDLE) |=> (q.state == BL_PRE && red_led))
        else $error("blink sequence did not start on a fault");
    fault_hold_a: assert property (
        @(posedge hclk) disable iff (!hresetn) q.fault |=> q.fault [*8])
        else $error("latched fault cleared without reset");
    cmd_code_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (!q.fault && q.s2[IX_CMD] && !q.cmd_prev) |=> (q.code == 4'h3 && q.arg == 5'h00))
        else $error("command error not reported as code three");
    wdog_bit_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (q.warm == 2'h3) |-> (q.status[11] == $past(watchdog_err, 3)))
        else $error("watchdog status bit does not follow the pin");
    async_bit_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (q.warm == 2'h3) |-> (q.status[15] == $past(bus_async, 3)))
        else $error("async status bit does not follow the pin");
    status_nonzero_a: assert property (
        @(posedge hclk) disable iff (!hresetn) q.fault |=> (q.status != 16'h0000))
        else $error("status reads zero while a fault is latched");
    green_clean_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        green_led |-> (!q.fault && $past(q.s2[IX_FB_RUN])))
        else $error("green lit during a fault or without fieldbus");
    seq_order_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(q.state == BL_ARG) |-> ($past(q.state) == BL_PAUSE && $past(q.arg) != 5'h00))
        else $error("argument group not preceded by the pause");
    code_count_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (q.state == BL_CODE) ##1 (q.state == BL_PAUSE) |-> ($past(q.cnt) == CNT_W'(q.code)))
        else $error("code group pulse count differs from the code");
    irq_level_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (q.irq_stat & q.irq_mask) != 4'h0 |-> irq)
        else $error("interrupt low while an unmasked event is pending");
endmodule : tbdb_blinker

// ### include/tbdb_pkg.sv
package tbdb_pkg;

    // ****************************************************************
    // Clock and blink timing
    // ****************************************************************
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned FAST_HALF_MS = 50;
    localparam int unsigned SLOW_HALF_MS = 250;
    localparam int unsigned PAUSE_MS = 1000;
    localparam int unsigned GAP_MS = 2000;
    localparam int unsigned FAST_HALF_CYC = CLK_HZ / 1000 * FAST_HALF_MS;
    localparam int unsigned SLOW_HALF_CYC = CLK_HZ / 1000 * SLOW_HALF_MS;
    localparam int unsigned PAUSE_CYC = CLK_HZ / 1000 * PAUSE_MS;
    localparam int unsigned GAP_CYC = CLK_HZ / 1000 * GAP_MS;
    localparam int unsigned TIMER_W = 26;
    localparam int unsigned CNT_W = 5;
    localparam logic [CNT_W-1:0] PREAMBLE_PULSES = 5'h08;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] STATUS_OFS = 8'h00;
    localparam logic [7:0] FAULT_OFS = 8'h04;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;
    localparam logic [7:0] CTRL_OFS = 8'h10;
    localparam logic CTRL_BLINK_EN_RST = 1'h1;
    localparam logic [3:0] IRQ_MASK_RST = 4'h0;

    // Status word bit positions.
    localparam int unsigned ST_FAULT = 0;
    localparam int unsigned ST_TERM_ERR = 1;
    localparam int unsigned ST_PD_LEN = 2;
    localparam int unsigned ST_NO_INPUT = 8;
    localparam int unsigned ST_IN_UPD = 9;
    localparam int unsigned ST_OUT_UPD = 10;
    localparam int unsigned ST_WDOG = 11;
    localparam int unsigned ST_ASYNC = 15;
    localparam logic [15:0] ST_ERR_MASK = 16'h8907;

    // Interrupt event bit positions.
    localparam int unsigned EV_FAULT = 0;
    localparam int unsigned EV_WDOG = 1;
    localparam int unsigned EV_TERM = 2;
    localparam int unsigned EV_ASYNC = 3;

    // Blink codes.
    localparam logic [3:0] CODE_CMD_ERR = 4'h3;
    localparam logic [3:0] CODE_PD_LEN = 4'h7;

    // Pin vector layout before synchronisation.
    localparam int unsigned IN_W = 34;
    localparam int unsigned IX_FB_RUN = 7;
    localparam int unsigned IX_CMD = 8;
    localparam int unsigned IX_STB = 9;
    localparam int unsigned IX_CODE = 10;
    localparam int unsigned IX_SLOT = 14;
    localparam int unsigned IX_PASSIVE = 18;

    typedef enum logic [2:0] {
        BL_IDLE = 3'b000,
        BL_PRE = 3'b001,
        BL_CODE = 3'b010,
        BL_PAUSE = 3'b011,
        BL_ARG = 3'b100,
        BL_GAP = 3'b101
    } tbdb_blink_e;

endpackage : tbdb_pkg

// ### sim/tbdb_term_chain.sv
`timescale 1ns/1ps
// ****************************************************************
// Attached terminal chain
// ****************************************************************
module tbdb_term_chain (
    // Clock
    input wire logic hclk,
    // Level pins toward the monitor
    output logic term_state_err,
    output logic no_valid_inputs,
    output logic in_update_busy,
    output logic out_update_busy,
    output logic watchdog_err,
    output logic bus_async,
    output logic pd_len_err,
    output logic cmd_err,
    output logic fieldbus_running,
    // Fault report
    output logic fault_strobe,
    output logic [3:0] fault_code,
    output logic [3:0] fault_slot,
    output logic [15:0] passive_map
);
    logic [8:0] lv = 9'h000;

    assign {fieldbus_running, cmd_err, pd_len_err, bus_async, watchdog_err} = lv[8:4];
    assign {out_update_busy, in_update_busy, no_valid_inputs, term_state_err} = lv[3:0];

    initial begin
        fault_strobe = 1'b0;
        fault_code = 4'h5;
        fault_slot = 4'ha;
        passive_map = 16'h0000;
    end

    task set_pin(input int i, input logic v);
        @(posedge hclk);
        lv[i] <= v;
    endtask : set_pin

    // slot and passive map
    // Code and slot are inverted once the hold time is over, so a late sample is caught.
    task report(input logic [3:0] c, input logic [3:0] s, input logic [15:0] pm);
        @(posedge hclk);
        fault_code <= c;
        fault_slot <= s;
        passive_map <= pm;
        repeat (4) @(posedge hclk);
        fault_strobe <= 1'b1;
        repeat (5) @(posedge hclk);
        fault_strobe <= 1'b0;
        fault_code <= ~c;
        fault_slot <= ~s;
    endtask : report
endmodule : tbdb_term_chain

// ### sim/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import tbdb_pkg::*;
;
    // ****************************************************************
    // Short blink timing keeps the run brief.
    // ****************************************************************
    localparam int FH = 4;
    localparam int SH = 8;
    localparam int PS = 16;
    localparam int GP = 40;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, red_led, green_led, irq;
    logic [31:0] haddr, hwdata, hrdata, rd, fw;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic term_state_err, no_valid_inputs, in_update_busy, out_update_busy, watchdog_err;
    logic bus_async, pd_len_err, cmd_err, fieldbus_running, fault_strobe;
    logic [3:0] fault_code, fault_slot, code, slot;
    logic [15:0] passive_map, pm;
    logic [31:0] rnd = 32'he1d7;
    int failures = 0;
    int compares = 0;
    int arg;
    int unsigned bitpos[6] = '{ST_TERM_ERR, ST_NO_INPUT, ST_IN_UPD, ST_OUT_UPD, ST_WDOG,
        ST_ASYNC};
    bit exp_q[$];

    assign hready = hreadyout;

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    tbdb_blinker #(.P_FAST_HALF(FH), .P_SLOW_HALF(SH), .P_PAUSE(PS), .P_GAP(GP)) u_tbdb_blinker (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .term_state_err(term_state_err),
        .pd_len_err(pd_len_err), .no_valid_inputs(no_valid_inputs),
        .in_update_busy(in_update_busy), .out_update_busy(out_update_busy),
        .watchdog_err(watchdog_err), .bus_async(bus_async), .fieldbus_running(fieldbus_running),
        .cmd_err(cmd_err), .fault_strobe(fault_strobe), .fault_code(fault_code),
        .fault_slot(fault_slot), .passive_map(passive_map), .red_led(red_led),
        .green_led(green_led), .irq(irq));

    tbdb_term_chain u_tbdb_term_chain (
        .hclk(hclk), .term_state_err(term_state_err), .no_valid_inputs(no_valid_inputs),
        .in_update_busy(in_update_busy), .out_update_busy(out_update_busy),
        .watchdog_err(watchdog_err), .bus_async(bus_async), .pd_len_err(pd_len_err),
        .cmd_err(cmd_err), .fieldbus_running(fieldbus_running), .fault_strobe(fault_strobe),
        .fault_code(fault_code), .fault_slot(fault_slot), .passive_map(passive_map));

    // ****************************************************************
    // Checking and bus tasks
    // ****************************************************************
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    task automatic test_done;
        if (failures == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string w);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t %s got %h exp %h", $time, w, got, exp);
        end
    endtask : chk_reg

    task automatic chk_pin(input logic got, input logic exp, input string w);
        chk_reg({31'h0, got}, {31'h0, exp}, w);
    endtask : chk_pin

    // The master holds each phase until hready is seen high; only the watchdog ends a hang.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string w);
        bus(1'b0, a, 32'h0);
        chk_reg(rd, exp, w);
    endtask : rchk

    task automatic settle;
        repeat (5) @(posedge hclk);
        @(negedge hclk);
    endtask : settle

    task automatic do_reset;
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
    endtask : do_reset

    task automatic seg(input int n, input bit v);
        repeat (n) exp_q.push_back(v);
    endtask : seg

    // Two whole sequences are compared cycle by cycle, from the first rise after a gap.
    task automatic blink(input int c, input int a, input string w);
        int bad;
        int lo;
        bad = 0;
        lo = 0;
        exp_q = {};
        repeat (2) begin
            repeat (PREAMBLE_PULSES) begin
                seg(FH, 1'b1);
                seg(FH, 1'b0);
            end
            repeat (c) begin
                seg(SH, 1'b1);
                seg(SH, 1'b0);
            end
            seg(PS, 1'b0);
            repeat (a) begin
                seg(SH, 1'b1);
                seg(SH, 1'b0);
            end
            seg(GP + 1, 1'b0);
        end
        @(negedge hclk);
        for (int k = 0; k < 3000 && !(red_led === 1'b1 && lo >= GP); k++) begin
            lo = (red_led === 1'b1) ? 0 : lo + 1;
            @(negedge hclk);
        end
        foreach (exp_q[k]) begin
            if (red_led !== exp_q[k])
                bad++;
            @(negedge hclk);
        end
        chk_reg(bad, 32'h0, w);
    endtask : blink

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        do_reset;
        rchk(STATUS_OFS, 32'h0, "status idle");
        rchk(IRQ_MASK_OFS, {28'h0, IRQ_MASK_RST}, "mask reset");
        rchk(CTRL_OFS, {31'h0, CTRL_BLINK_EN_RST}, "ctrl reset");
        rchk(8'h40, 32'h0, "unmapped");
        settle;
        chk_pin(hresp, 1'b0, "okay response");
        chk_pin(hreadyout, 1'b1, "no wait states");
        chk_pin(green_led, 1'b0, "green no fieldbus");
        u_tbdb_term_chain.set_pin(8, 1'b1);
        for (int i = 0; i < 6; i++) begin
            u_tbdb_term_chain.set_pin(i, 1'b1);
            settle;
            chk_pin(green_led, (i == 2 || i == 3), "green");
            chk_pin(red_led, 1'b0, "red dark");
            rchk(STATUS_OFS, 32'h1 << bitpos[i], "status bit");
            u_tbdb_term_chain.set_pin(i, 1'b0);
        end
        settle;
        rchk(IRQ_STAT_OFS, 32'he, "irq events");
        chk_pin(irq, 1'b0, "irq masked");
        bus(1'b1, IRQ_MASK_OFS, 32'h2);
        settle;
        chk_pin(irq, 1'b1, "irq raised");
        bus(1'b1, IRQ_STAT_OFS, 32'h2);
        settle;
        chk_pin(irq, 1'b0, "irq cleared");
        rchk(IRQ_STAT_OFS, 32'hc, "irq w1c");
        bus(1'b1, CTRL_OFS, 32'h0);
        rchk(CTRL_OFS, 32'h0, "ctrl rw");
        bus(1'b1, CTRL_OFS, 32'h1);
        rnd = lfsr_next(rnd);
        code = rnd[3:0] | 4'h1;
        slot = rnd[7:4];
        pm = rnd[23:8];
        arg = 0;
        for (int i = 0; i < slot; i++)
            arg += !pm[i];
        fw = {19'h0, arg[4:0], code, 4'h1};
        u_tbdb_term_chain.report(code, slot, pm);
        settle;
        rchk(FAULT_OFS, fw, "fault word");
        rchk(STATUS_OFS, 32'h1, "status fault");
        chk_pin(green_led, 1'b0, "green fault");
        blink(code, arg, "blink seq");
        u_tbdb_term_chain.report(4'h2, 4'h1, 16'h0);
        settle;
        rchk(FAULT_OFS, fw, "first fault kept");
        do_reset;
        u_tbdb_term_chain.set_pin(7, 1'b1);
        settle;
        u_tbdb_term_chain.set_pin(7, 1'b0);
        settle;
        rchk(FAULT_OFS, {24'h0, CODE_CMD_ERR, 4'h1}, "cmd fault");
        blink(3, 0, "cmd blink");
        do_reset;
        u_tbdb_term_chain.report(4'h0, 4'h3, 16'h0);
        settle;
        chk_pin(red_led, 1'b0, "zero code dark");
        rchk(FAULT_OFS, 32'h0, "zero code refused");
        u_tbdb_term_chain.set_pin(6, 1'b1);
        settle;
        rchk(STATUS_OFS, 32'h5, "pd len");
        u_tbdb_term_chain.set_pin(6, 1'b0);
        settle;
        rchk(FAULT_OFS, {24'h0, CODE_PD_LEN, 4'h1}, "pd fault");
        test_done;
    end

    initial begin
        #(100 * 20000);
        failures++;
        test_done;
    end
endmodule : tb_top
